// *** include/etc_pkg.sv ***
// Shared constants of the 8-bit timer/counter core
package etc_pkg;

	// Bus geometry
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          CNT_W           = 8;

	// Register byte offsets, one aligned word each
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_COUNT       = 8'h04;
	localparam logic [7:0]  OFS_COMPARE     = 8'h08;
	localparam logic [7:0]  OFS_FLAGS       = 8'h0C;
	localparam logic [7:0]  OFS_MASK        = 8'h10;
	localparam logic [7:0]  OFS_STATUS      = 8'h14;

	// Control register field positions
	localparam int          CTRL_WGM_LSB    = 0;
	localparam int          CTRL_CS_LSB     = 2;
	localparam int          CTRL_TOGGLE_BIT = 5;
	localparam int          CTRL_W          = 6;

	// Flag and mask bit positions
	localparam int          FLG_OVF_BIT     = 0;
	localparam int          FLG_CMP_BIT     = 1;
	localparam int          FLG_W           = 2;

	// Status register bit positions
	localparam int          ST_BOTTOM_BIT   = 0;
	localparam int          ST_MATCH_BIT    = 1;
	localparam int          ST_DOWN_BIT     = 2;
	localparam int          ST_W            = 3;

	// Counter limits
	localparam logic [7:0]  CNT_BOTTOM      = 8'h00;
	localparam logic [7:0]  CNT_MAX         = 8'hFF;

	// Reset values
	localparam logic [5:0]  CTRL_RST        = 6'h00;
	localparam logic [7:0]  COUNT_RST       = 8'h00;
	localparam logic [7:0]  COMPARE_RST     = 8'h00;
	localparam logic [1:0]  FLAGS_RST       = 2'h0;
	localparam logic [1:0]  MASK_RST        = 2'h0;

	// Waveform modes
	localparam logic [1:0]  WGM_NORMAL      = 2'h0;
	localparam logic [1:0]  WGM_UPDOWN      = 2'h1;
	localparam logic [1:0]  WGM_CTC         = 2'h2;
	localparam logic [1:0]  WGM_FAST        = 2'h3;

	// Clock select codes
	localparam logic [2:0]  CS_STOP         = 3'h0;
	localparam logic [2:0]  CS_DIV1         = 3'h1;
	localparam logic [2:0]  CS_DIV8         = 3'h2;
	localparam logic [2:0]  CS_DIV64        = 3'h3;
	localparam logic [2:0]  CS_DIV256       = 3'h4;
	localparam logic [2:0]  CS_DIV1024      = 3'h5;
	localparam logic [2:0]  CS_EXT_FALL     = 3'h6;
	localparam logic [2:0]  CS_EXT_RISE     = 3'h7;

	// Prescaler width, ten bits for the divide-by-1024 tap
	localparam int          PRE_W           = 10;

	// Prescaler tap masks: all bits below each divide point
	localparam logic [9:0]  PRE_TAP8        = 10'h007;
	localparam logic [9:0]  PRE_TAP64       = 10'h03F;
	localparam logic [9:0]  PRE_TAP256      = 10'h0FF;
	localparam logic [9:0]  PRE_TAP1024     = 10'h3FF;

endpackage : etc_pkg

// *** src/etc_timer.sv ***
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns

// Contract
// R1 - 8-bit counter counts up or down
// R2 - Value 0x00 is BOTTOM, signalled
// R3 - Value 0xFF is MAX
// R4 - TOP is 0xFF or compare value
// R5 - Tick from prescaler or external edge
// R6 - Clock select zero stops the counter
// R7 - Each tick clears, increments or decrements
// R8 - CPU reads/writes counter any time
// R9 - CPU counter write beats counting action
// R10 - Compare always; match output on equality
// R11 - Compare match sets compare flag
// R12 - Flags register, per-bit mask register
// R13 - Two mode bits choose count sequence
// R14 - Overflow flag set per mode, interrupts
// R15 - Normal mode counts up, wraps 0xFF
// R16 - Normal overflow when counter becomes zero
// R17 - CTC mode clears counter on match
// R18 - Compare flag one tick after equality
// R19 - Reset clears all, timer stopped
module etc_timer (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Wishbone classic slave
	input  wire logic                          cyc_i,
	input  wire logic                          stb_i,
	input  wire logic                          we_i,
	input  wire logic [etc_pkg::ADDR_W-1:0]    adr_i,
	input  wire logic [3:0]                    sel_i,
	input  wire logic [etc_pkg::DATA_W-1:0]    dat_i,
	output logic      [etc_pkg::DATA_W-1:0]    dat_o,
	output logic                               ack_o,
	// Pins
	input  wire logic                          external_count_input_i,
	output logic                               compare_output_pin_o,
	// Core signals towards a waveform generator
	output logic                               compare_match_o,
	output logic                               bottom_o,
	output logic                               top_o,
	// Interrupt request
	output logic                               irq_o
);

	// Byte-address decode of one register word
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	// Prescaler tap reached: all bits below the tap are ones
	// One shared counter serves every rate, so no divider per rate
	function automatic logic tap_full(input logic [9:0] p, input logic [9:0] msk);
		tap_full = ((p & msk) == msk);
	endfunction : tap_full

	// Software-visible state
	logic [5:0]                 ctrl_q;         // Mode, clock select, toggle
	logic [7:0]                 counter_value_q;  // Counter
	logic [7:0]                 counter_value_d;  // Counter next value
	logic [7:0]                 compare_value_q;  // Compare register
	logic [1:0]                 timer_flag_register_q;  // Sticky events
	logic [1:0]                 timer_flag_register_d;  // Next flags
	logic [1:0]                 timer_mask_register_q;  // Event mask
	logic                       down_q;         // Counting direction
	logic                       down_d;         // Next direction
	logic                       block_q;        // Match blocked after write
	logic [9:0]                 pre_q;          // Prescaler
	logic                       ack_q;          // Bus answer
	logic [31:0]                rdat_q;         // Read data
	logic                       pin_q;          // Compare output level
	logic                       match_q;        // Registered equality
	logic                       bottom_q;       // Registered bottom
	logic                       top_q;          // Registered top
	logic                       irq_q;          // Registered interrupt

	// External input synchroniser and filtered level
	logic                       ext_s1_q;       // First stage, read only by second
	logic                       ext_s2_q;       // Second stage
	logic                       ext_s3_q;       // Third stage
	logic                       ext_lvl_q;      // Accepted level

	// Field views of the control register
	wire  [1:0]                 waveform_mode_field = ctrl_q[etc_pkg::CTRL_WGM_LSB +: 2];
	wire  [2:0]                 clock_select_field  = ctrl_q[etc_pkg::CTRL_CS_LSB +: 3];
	wire                        toggle_en           = ctrl_q[etc_pkg::CTRL_TOGGLE_BIT];

	// Bus decode
	// A strobe held past ack starts a new request, so ack alternates
	wire                        bus_req  = cyc_i & stb_i & ~ack_q;
	wire                        bus_wr   = bus_req & we_i & sel_i[0];
	wire                        wr_ctrl  = bus_wr & hit(adr_i, etc_pkg::OFS_CTRL);
	wire                        wr_cnt   = bus_wr & hit(adr_i, etc_pkg::OFS_COUNT);
	wire                        wr_cmp   = bus_wr & hit(adr_i, etc_pkg::OFS_COMPARE);
	wire                        wr_flg   = bus_wr & hit(adr_i, etc_pkg::OFS_FLAGS);
	wire                        wr_msk   = bus_wr & hit(adr_i, etc_pkg::OFS_MASK);

	// Read multiplexer, unmapped words read zero
	// Only address bits 7:2 decode, so byte offsets alias their word
	wire  [31:0]                rd_mux =
		hit(adr_i, etc_pkg::OFS_CTRL)    ? {26'h000_0000, ctrl_q} :
		hit(adr_i, etc_pkg::OFS_COUNT)   ? {24'h00_0000, counter_value_q} :
		hit(adr_i, etc_pkg::OFS_COMPARE) ? {24'h00_0000, compare_value_q} :
		hit(adr_i, etc_pkg::OFS_FLAGS)   ? {30'h0000_0000, timer_flag_register_q} :
		hit(adr_i, etc_pkg::OFS_MASK)    ? {30'h0000_0000, timer_mask_register_q} :
		hit(adr_i, etc_pkg::OFS_STATUS)  ? {29'h0000_0000, down_q, match_q, bottom_q} :
		32'h0000_0000;

	// Clock source selection
	// R5 prescaler taps
	wire                        pre_tick =
		(clock_select_field == etc_pkg::CS_DIV1)    ? 1'b1 :
		(clock_select_field == etc_pkg::CS_DIV8)    ? tap_full(pre_q, etc_pkg::PRE_TAP8) :
		(clock_select_field == etc_pkg::CS_DIV64)   ? tap_full(pre_q, etc_pkg::PRE_TAP64) :
		(clock_select_field == etc_pkg::CS_DIV256)  ? tap_full(pre_q, etc_pkg::PRE_TAP256) :
		(clock_select_field == etc_pkg::CS_DIV1024) ? tap_full(pre_q, etc_pkg::PRE_TAP1024) :
		1'b0;
	// Edge found on the filtered level, never on a raw stage
	// R5 external edge choice
	wire                        ext_new  = (ext_s2_q == ext_s3_q) & (ext_s3_q != ext_lvl_q);
	wire                        ext_tick =
		(clock_select_field == etc_pkg::CS_EXT_RISE) ? (ext_new & ext_s3_q) :
		(clock_select_field == etc_pkg::CS_EXT_FALL) ? (ext_new & ~ext_s3_q) :
		1'b0;
	// R6 no source, no tick
	wire                        timer_clock_tick = (clock_select_field != etc_pkg::CS_STOP) & (pre_tick | ext_tick);

	// Limits of the present count
	// R2 bottom value
	wire                        at_bottom = (counter_value_q == etc_pkg::CNT_BOTTOM);
	// R3 max value
	wire                        at_max    = (counter_value_q == etc_pkg::CNT_MAX);
	// R10 continuous comparator
	wire                        equal     = (counter_value_q == compare_value_q);
	// R4 top per mode
	wire                        at_top    = (waveform_mode_field == etc_pkg::WGM_CTC) ? equal : at_max;
	// Blocking lasts until the next tick, however long that takes
	// R18 a blocked match is dropped
	wire                        match_evt = timer_clock_tick & equal & ~block_q;

	// Counter next value and direction
	// Fast mode is a plain wrap; its only waveform is the match toggle that every mode has
	always_comb begin
		counter_value_d = counter_value_q;
		down_d          = down_q;
		// R9 CPU write wins
		if (wr_cnt) begin
			counter_value_d = dat_i[7:0];
		end else if (timer_clock_tick) begin
			// R7 per-tick action
			// R13 mode picks sequence
			case (waveform_mode_field)
				// R15 plain up count with wrap
				etc_pkg::WGM_NORMAL: begin
					counter_value_d = counter_value_q + 8'h01;
				end
				// R17 clear at compare
				etc_pkg::WGM_CTC: begin
					// Here TOP is the compare value
					counter_value_d = at_top ? etc_pkg::CNT_BOTTOM : counter_value_q + 8'h01;
				end
				// R1 up then down
				etc_pkg::WGM_UPDOWN: begin
					if (down_q & at_bottom) begin
						// BOTTOM written while falling: turn upward, no wrap
						counter_value_d = counter_value_q + 8'h01;
						down_d          = 1'b0;
					end else if (down_q) begin
						counter_value_d = counter_value_q - 8'h01;
						down_d          = (counter_value_q != 8'h01);
					end else begin
						counter_value_d = counter_value_q + 8'h01;
						down_d          = (counter_value_q == 8'hFE);
					end
				end
				// Fast mode wraps after MAX
				default: begin
					counter_value_d = counter_value_q + 8'h01;
				end
			endcase
		end
	end

	// Flag next value, a set wins over a clear
	// The clear is applied first, so an event in the same cycle overrides it
	always_comb begin
		timer_flag_register_d = timer_flag_register_q;
		// Write one to clear
		if (wr_flg) begin
			timer_flag_register_d = timer_flag_register_q & ~dat_i[1:0];
		end
		// Up/down mode overflows on the step from 01 to 00 while falling
		// R14 overflow condition per mode
		if (timer_clock_tick & ~wr_cnt) begin
			// R16 set as count becomes zero
			if ((waveform_mode_field == etc_pkg::WGM_UPDOWN) ? (down_q & counter_value_q == 8'h01) : at_max) begin
				timer_flag_register_d[etc_pkg::FLG_OVF_BIT] = 1'b1;
			end
		end
		// R11 match sets flag
		if (match_evt) begin
			timer_flag_register_d[etc_pkg::FLG_CMP_BIT] = 1'b1;
		end
	end

	// Bus answer, one cycle after the strobe
	// Read data is zero outside ack so a stale word is never mistaken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= bus_req;
			rdat_q <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	// Software registers
	// Reset leaves the clock select at zero, so nothing counts
	// R19 all cleared, stopped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q                <= etc_pkg::CTRL_RST;
			compare_value_q       <= etc_pkg::COMPARE_RST;
			timer_mask_register_q <= etc_pkg::MASK_RST;
		end else begin
			// Mode and source change at the write edge
			if (wr_ctrl) begin
				ctrl_q <= dat_i[5:0];
			end
			// Compare written directly, no buffering
			if (wr_cmp) begin
				compare_value_q <= dat_i[7:0];
			end
			// R12 per-event mask
			if (wr_msk) begin
				timer_mask_register_q <= dat_i[1:0];
			end
		end
	end

	// Counter, direction and flags
	// Direction is internal state; software sees it only in status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_value_q       <= etc_pkg::COUNT_RST;
			down_q                <= 1'b0;
			timer_flag_register_q <= etc_pkg::FLAGS_RST;
		end else begin
			// R8 access at any time
			counter_value_q       <= counter_value_d;
			down_q                <= down_d;
			// R12 flags visible to software
			timer_flag_register_q <= timer_flag_register_d;
		end
	end

	// Match blocking after a counter write
	// A write holds off the next tick's match even while stopped,
	// so software may preload equal values without a false event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			block_q <= 1'b0;
		end else if (wr_cnt) begin
			block_q <= 1'b1;
		end else if (timer_clock_tick) begin
			block_q <= 1'b0;
		end
	end

	// Prescaler runs whenever the clock select is not zero, external sources included
	// Held at zero while stopped, so the first tick is a full period away
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_q <= 10'h000;
		end else if (clock_select_field == etc_pkg::CS_STOP) begin
			pre_q <= 10'h000;
		end else begin
			pre_q <= pre_q + 10'h001;
		end
	end

	// External input synchroniser, level accepted when stages agree
	// The first stage may go metastable; only the later two are trusted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_q  <= 1'b0;
			ext_s2_q  <= 1'b0;
			ext_s3_q  <= 1'b0;
			ext_lvl_q <= 1'b0;
		end else begin
			ext_s1_q <= external_count_input_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q) begin
				ext_lvl_q <= ext_s3_q;
			end
		end
	end

	// Compare output pin toggles on each unblocked match
	// Toggle only; set and clear actions on a match are not offered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 1'b0;
		end else if (match_evt & toggle_en) begin
			pin_q <= ~pin_q;
		end
	end

	// Registered core signals and interrupt
	// Next values are compared so these outputs line up with the counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_q  <= 1'b0;
			bottom_q <= 1'b0;
			top_q    <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			// R10 equality of next values
			match_q  <= (counter_value_d == compare_value_q);
			// R2 counter becomes zero
			bottom_q <= (counter_value_d == etc_pkg::CNT_BOTTOM);
			top_q    <= (waveform_mode_field == etc_pkg::WGM_CTC) ?
			            (counter_value_d == compare_value_q) : (counter_value_d == etc_pkg::CNT_MAX);
			// Next flags used, so the request rises in the same cycle as its flag
			// R12 mask gates requests
			irq_q    <= |(timer_flag_register_d & timer_mask_register_q);
		end
	end

	// Outputs straight from flops
	// One cycle of delay traded for glitch-free ports
	assign dat_o                = rdat_q;
	assign ack_o                = ack_q;
	assign compare_output_pin_o = pin_q;
	assign compare_match_o      = match_q;
	assign bottom_o             = bottom_q;
	assign top_o                = top_q;
	assign irq_o                = irq_q;

endmodule : etc_timer

// *** bench/etc_timer_checker.sv ***
`timescale 1ns/1ns

// Port-level checks of the timer core
module etc_timer_checker (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Bus side
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	// Interrupt
	input  wire logic        irq_o
);
	// Request taken at this edge
	logic       take;
	// Address and direction of the request in flight
	logic [7:0] adr_q;
	logic       we_q;
	// Read answers, by target
	logic       rd_q;

	assign take = cyc_i & stb_i & ~ack_o;
	assign rd_q = ack_o & ~we_q;

	// Latch the request so the answer can be judged by target
	always_ff @(posedge clk_i) begin
		if (take) begin
			adr_q <= adr_i;
			we_q  <= we_i;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_single : assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_answer : assert property (take |=> ack_o)
		else $error("request not answered next cycle");
	chk_ack_cause : assert property (ack_o |-> $past(take))
		else $error("ack without a request");
	chk_data_idle : assert property (!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	chk_byte_wide : assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
		else $error("bits above the byte not zero");
	chk_gap_zero : assert property (rd_q && adr_q > 8'h17 |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_flag_width : assert property (rd_q && adr_q inside {8'h0C, 8'h10} |-> dat_o[7:2] == 6'h00)
		else $error("flag or mask spare bits set");
	chk_status_width : assert property (rd_q && adr_q == 8'h14 |-> dat_o[7:3] == 5'h00)
		else $error("status spare bits set");
	chk_irq_clear : assert property ($fell(irq_o) |-> (ack_o && we_q) || $past(ack_o && we_q))
		else $error("interrupt dropped without a write");
endmodule : etc_timer_checker

bind etc_timer etc_timer_checker chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o)
);

// *** bench/tb_etc_timer.sv ***
`timescale 1ns/1ns

// Self-checking bench of the timer core
module tb_etc_timer;
	// Drives and observed outputs
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ext_pin, irq_o, ack_o;
	logic        compare_output_pin_o, compare_match_o, bottom_o, top_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o;
	int          miscompares, compares;
	localparam logic [31:0] ZERO = 32'h0000_0000;

	etc_timer dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.external_count_input_i(ext_pin), .compare_output_pin_o(compare_output_pin_o),
		.compare_match_o(compare_match_o), .bottom_o(bottom_o), .top_o(top_o), .irq_o(irq_o)
	);

	// Compare one value, count and report
	task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// One classic cycle; waits for ack, no fixed latency assumed
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, ZERO, r);
		check(nm, exp, r);
	endtask : rdc

	// Whole map after reset, one unmapped word at the end
	task t_reset;
		for (int i = 0; i < 7; i++) begin
			rdc("reset map", 8'(i * 4), (i == 5) ? 32'h0000_0003 : ZERO);
		end
		check("bottom at reset", 32'h0000_0001, bottom_o);
		check("match at reset", 32'h0000_0001, compare_match_o);
		check("top at reset", ZERO, top_o);
		check("pin at reset", ZERO, compare_output_pin_o);
		$display("test reset done");
	endtask : t_reset

	// Stopped timer keeps a written count
	task t_stop;
		wr(etc_pkg::OFS_COUNT, 32'h0000_005A);
		wr(etc_pkg::OFS_COMPARE, 32'h0000_00A5);
		repeat (20) @(posedge clk_i);
		rdc("count held", etc_pkg::OFS_COUNT, 32'h0000_005A);
		rdc("compare", etc_pkg::OFS_COMPARE, 32'h0000_00A5);
		check("match idle", ZERO, compare_match_o);
		check("bottom idle", ZERO, bottom_o);
		wr(etc_pkg::OFS_COUNT, 32'h0000_00FF);
		check("top at max", 32'h0000_0001, top_o);
		$display("test stop done");
	endtask : t_stop

	// Wrap from FE in normal mode raises overflow
	task t_ovf;
		int k;
		wr(etc_pkg::OFS_COUNT, 32'h0000_00FE);
		wr(etc_pkg::OFS_MASK, 32'h0000_0001);
		wr(etc_pkg::OFS_CTRL, 32'h0000_0004);
		k = 0;
		while (irq_o !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		check("overflow irq", 32'h0000_0001, irq_o);
		// Written at a tick edge; two later ticks before the read is taken
		wr(etc_pkg::OFS_COUNT, 32'h0000_0040);
		rdc("write wins", etc_pkg::OFS_COUNT, 32'h0000_0042);
		wr(etc_pkg::OFS_CTRL, ZERO);
		rdc("overflow flag", etc_pkg::OFS_FLAGS, 32'h0000_0001);
		wr(etc_pkg::OFS_FLAGS, 32'h0000_0001);
		rdc("flag cleared", etc_pkg::OFS_FLAGS, ZERO);
		check("irq low", ZERO, irq_o);
		$display("test overflow done");
	endtask : t_ovf

	// Clear on compare keeps the count at or below three
	task t_ctc;
		logic [31:0] r;
		wr(etc_pkg::OFS_COUNT, ZERO);
		wr(etc_pkg::OFS_COMPARE, 32'h0000_0003);
		wr(etc_pkg::OFS_MASK, 32'h0000_0002);
		wr(etc_pkg::OFS_CTRL, 32'h0000_0006);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, etc_pkg::OFS_COUNT, ZERO, r);
			check("ctc range", 32'h0000_0001, {31'h0000_0000, r <= 32'h0000_0003});
		end
		wr(etc_pkg::OFS_CTRL, ZERO);
		check("compare irq", 32'h0000_0001, irq_o);
		rdc("compare flag", etc_pkg::OFS_FLAGS, 32'h0000_0002);
		wr(etc_pkg::OFS_FLAGS, 32'h0000_0003);
		$display("test ctc done");
	endtask : t_ctc

	// External pin counts on rising then on falling edges
	task t_ext;
		for (int s = 0; s < 2; s++) begin
			wr(etc_pkg::OFS_CTRL, ZERO);
			wr(etc_pkg::OFS_COUNT, ZERO);
			wr(etc_pkg::OFS_CTRL, s ? 32'h0000_0018 : 32'h0000_001C);
			repeat (3) begin
				ext_pin <= 1'b1;
				repeat (8) @(posedge clk_i);
				ext_pin <= 1'b0;
				repeat (8) @(posedge clk_i);
			end
			wr(etc_pkg::OFS_CTRL, ZERO);
			rdc("ext count", etc_pkg::OFS_COUNT, 32'h0000_0003);
		end
		$display("test external done");
	endtask : t_ext

	// Up/down mode turns at MAX and overflows on reaching BOTTOM
	task t_updown;
		logic [31:0] r1, r2;
		wr(etc_pkg::OFS_COMPARE, 32'h0000_0080);
		wr(etc_pkg::OFS_COUNT, 32'h0000_00FE);
		wr(etc_pkg::OFS_CTRL, 32'h0000_0005);
		bus(1'b0, etc_pkg::OFS_COUNT, ZERO, r1);
		bus(1'b0, etc_pkg::OFS_COUNT, ZERO, r2);
		check("falling count", 32'h0000_0001, {31'h0000_0000, r2 < r1});
		wr(etc_pkg::OFS_CTRL, ZERO);
		rdc("down status", etc_pkg::OFS_STATUS, 32'h0000_0004);
		wr(etc_pkg::OFS_COUNT, 32'h0000_0003);
		wr(etc_pkg::OFS_FLAGS, 32'h0000_0003);
		wr(etc_pkg::OFS_CTRL, 32'h0000_0005);
		repeat (10) @(posedge clk_i);
		wr(etc_pkg::OFS_CTRL, ZERO);
		rdc("bottom overflow", etc_pkg::OFS_FLAGS, 32'h0000_0001);
		wr(etc_pkg::OFS_FLAGS, 32'h0000_0003);
		$display("test updown done");
	endtask : t_updown

	// Divide-by-8 ticks, clear on compare and a pin toggle on the match
	task t_pre;
		int k;
		wr(etc_pkg::OFS_COUNT, ZERO);
		wr(etc_pkg::OFS_COMPARE, 32'h0000_0002);
		wr(etc_pkg::OFS_CTRL, 32'h0000_002A);
		k = 0;
		while (compare_output_pin_o !== 1'b1 && k < 100) begin
			@(posedge clk_i);
			k++;
		end
		// Three ticks of eight cycles: 0 to 1, 1 to 2, then the match
		check("prescaled match", 32'h0000_0018, k);
		wr(etc_pkg::OFS_CTRL, ZERO);
		rdc("ctc cleared", etc_pkg::OFS_COUNT, ZERO);
		rdc("match flag", etc_pkg::OFS_FLAGS, 32'h0000_0002);
		wr(etc_pkg::OFS_FLAGS, 32'h0000_0003);
		$display("test prescaler done");
	endtask : t_pre

	// Verdict and end of run
	task end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test

	// Free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Cuts a hang well past the expected run length
	initial begin
		#100000;
		miscompares++;
		end_of_test;
	end

	// Main sequence
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = ZERO;
		ext_pin = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_stop;
		t_ovf;
		t_ctc;
		t_ext;
		t_updown;
		t_pre;
		end_of_test;
	end
endmodule : tb_etc_timer
